// ===== design/psmc_defines.vh
`ifndef PSMC_DEFINES_VH
`define PSMC_DEFINES_VH

// Register byte offsets
`define PSMC_OFS_CTRL     8'h00
`define PSMC_OFS_WAKE     8'h04
`define PSMC_OFS_SCR0     8'h08
`define PSMC_OFS_SCR1     8'h0C
`define PSMC_OFS_RCAUSE   8'h10
`define PSMC_OFS_STATUS   8'h14
`define PSMC_OFS_CFG      8'h18

// Deep sleep control fields
`define PSMC_CTRL_ARM     15
`define PSMC_CTRL_BOR     1
`define PSMC_CTRL_HOLD    0
// Reset cause field
`define PSMC_RC_DEEP      10
// Wake source flag fields
`define PSMC_WK_INT0      0
`define PSMC_WK_DEEP_SLEEP_WATCHDOG     1
`define PSMC_WK_CAL       2
`define PSMC_WK_MASTER_CLEAR_PIN      3
`define PSMC_WK_POR       4
// Configuration fields
`define PSMC_CFG_WDTEN    0
`define PSMC_CFG_CALEN    1
`define PSMC_CFG_CALRC    2
`define PSMC_CFG_WDTRC    3
`define PSMC_CFG_CLOCK_FAIL_MONITOR     4
`define PSMC_CFG_INT0EN   5
`define PSMC_CFG_INT0POL  6

// Power-save operands
`define PSMC_OP_SLEEP     1'b0
`define PSMC_OP_IDLE      1'b1

// Arm window: one instruction cycle, two clocks per instruction
`define PSMC_TCY_NS       16
`define PSMC_CLK_NS       8
`define PSMC_ARM_CYC      2'h2
// Exit reset sequence length in clocks
`define PSMC_POR_CYC      8'h10

`endif

// ===== design/psmc_power_save_mode_controller.v
`timescale 1ns/1ps
`include "psmc_defines.vh"

// Summary of operation
// - Sleep entry stops the system clock, its oscillator, and execution.
// - In Sleep pin directions and outputs stay frozen at entry values.
// - In Sleep the RC clock runs if watchdog or calendar use it.
// - Watchdog counter is cleared on entry to Sleep and to Idle.
// - Sleep or Idle end on enabled interrupt, reset or watchdog time-out.
// - Sleep wake restarts with the clock source selected at entry.
// - Idle stops the processor; system clock and peripherals keep running.
// - In Idle the RC clock runs if watchdog or clock monitor enabled.
// - Idle wake restores processor clock and resumes at once.
// - Interrupt during the instruction is held, then wakes right after entry.
// - Deep Sleep stops clocks, peripherals, freezes pins, powers memories off.
// - Arm bit clears if Sleep instruction misses one-instruction window.
// - Arm bit clears automatically on Deep Sleep exit.
// - Setting the arm bit clears all wake source flags.
// - Deep exit on power-on, deep watchdog, calendar alarm, or master clear low.
// - Interrupt 0 wakes Deep Sleep if enabled, at polarity, on a change.
// - Pending interrupts are discarded on Deep Sleep entry.
// - Deep exit is a power-on reset; calendar, scratch, watchdog bit kept.
// - Wake events during the exit reset sequence are ignored, not recorded.
// - Deep exit sets exit flag in reset cause, runs from reset vector.
// - Brownout during Deep Sleep sets the brownout event bit.
// - Both scratch registers keep contents through Deep Sleep and exit reset.
// - Pins stay held after Deep Sleep wake until firmware clears the hold bit.
// - Sleep instruction enters Deep Sleep with arm set, Sleep otherwise.
module psmc_power_save_mode_controller (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        saveInstr,
  input  wire        saveOperand,
  input  wire        irqPending,
  input  wire        wdtTimeout,
  input  wire        deepWdtTimeout,
  input  wire        calAlarm,
  input  wire        masterClearN,
  input  wire        supplyPor,
  input  wire        brownout,
  input  wire        int0Pin,
  output reg         cpuRun,
  output reg         sysClkOn,
  output reg         oscOn,
  output reg         periphClkOn,
  output reg         lowPowerRcOn,
  output reg         ioFreeze,
  output reg         memPowerOn,
  output reg         wdtClear,
  output reg         irqDiscard,
  output reg         wakeToIsr,
  output reg         devicePorRst,
  output reg  [2:0]  clkSelRestore
);

  localparam [5:0] ST_RUN   = 6'h01;
  localparam [5:0] ST_SLEEP = 6'h02;
  localparam [5:0] ST_IDLE  = 6'h04;
  localparam [5:0] ST_DEEP  = 6'h08;
  localparam [5:0] ST_POR   = 6'h10;
  localparam [5:0] ST_WAKE  = 6'h20;

  reg [5:0]  state_q;
  reg [5:0]  state_d;
  reg        arm_q;
  reg [1:0]  armCnt_q;
  reg        bor_q;
  reg        hold_q;
  reg [4:0]  wake_q;
  reg [31:0] scr0_q;
  reg [31:0] scr1_q;
  reg        deepExit_q;
  reg [6:0]  cfg_q;
  reg [2:0]  clkSel_q;
  reg        int0Prev_q;
  reg [7:0]  porCnt_q;
  reg [31:0] rdMux;

  // One register decoder shared by every write path
  function regHit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      regHit = (a == ofs);
    end
  endfunction

  // Out-of-map or unaligned offsets answer with an error and read as 0
  function badAddr;
    input [7:0] a;
    begin
      badAddr = (a > `PSMC_OFS_CFG) | (a[1:0] != 2'h0);
    end
  endfunction

  wire access   = psel & penable & pready;
  wire wrAcc    = access & pwrite;
  wire wrCtrl   = wrAcc & regHit(paddr, `PSMC_OFS_CTRL);
  wire wrScr0   = wrAcc & regHit(paddr, `PSMC_OFS_SCR0);
  wire wrScr1   = wrAcc & regHit(paddr, `PSMC_OFS_SCR1);
  wire wrCfg    = wrAcc & regHit(paddr, `PSMC_OFS_CFG);
  wire wrRcause = wrAcc & regHit(paddr, `PSMC_OFS_RCAUSE);
  wire wrStatus = wrAcc & regHit(paddr, `PSMC_OFS_STATUS);
  wire armSet   = wrCtrl & pwdata[`PSMC_CTRL_ARM] & ~arm_q;
  wire wakeLite = irqPending | wdtTimeout | supplyPor | ~masterClearN;
  wire int0Hit  = cfg_q[`PSMC_CFG_INT0EN] & (int0Pin != int0Prev_q) &
                  (int0Pin == cfg_q[`PSMC_CFG_INT0POL]);
  wire [4:0] deepEv = {supplyPor, ~masterClearN,
                       calAlarm & cfg_q[`PSMC_CFG_CALEN],
                       deepWdtTimeout, int0Hit};
  wire rcNeedSleep = (cfg_q[`PSMC_CFG_WDTEN] & cfg_q[`PSMC_CFG_WDTRC]) |
                     (cfg_q[`PSMC_CFG_CALEN] & cfg_q[`PSMC_CFG_CALRC]);
  wire rcNeedIdle  = cfg_q[`PSMC_CFG_WDTEN] | cfg_q[`PSMC_CFG_CLOCK_FAIL_MONITOR];
  // Deep Sleep entry and exit events, shared by the flag and mode logic
  wire enterDeep = state_q[0] & saveInstr &
                   (saveOperand == `PSMC_OP_SLEEP) & arm_q;
  wire exitDeep  = state_q[3] & (|deepEv);

  // Combined one-hot state decode used by the ioFreeze output
  function isLowPower;
    input [5:0] s;
    begin
      isLowPower = s[1] | s[2] | s[3];
    end
  endfunction

  // APB slave, zero wait states
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata  <= rdMux;
        pslverr <= badAddr(paddr);
      end
    end
  end

  always @* begin
    rdMux = 32'h00000000;
    case (paddr)
      `PSMC_OFS_CTRL: begin
        rdMux[`PSMC_CTRL_ARM]  = arm_q;
        rdMux[`PSMC_CTRL_BOR]  = bor_q;
        rdMux[`PSMC_CTRL_HOLD] = hold_q;
      end
      `PSMC_OFS_WAKE:   rdMux[4:0] = wake_q;
      `PSMC_OFS_SCR0:   rdMux = scr0_q;
      `PSMC_OFS_SCR1:   rdMux = scr1_q;
      `PSMC_OFS_RCAUSE: rdMux[`PSMC_RC_DEEP] = deepExit_q;
      `PSMC_OFS_STATUS: rdMux[5:0] = state_q;
      `PSMC_OFS_CFG:    rdMux[6:0] = cfg_q;
      default:          rdMux = 32'h00000000;
    endcase
  end

  // Retained across deep exit: only sys_rst (true power-on) clears these
  always @(posedge clk) begin
    if (sys_rst) begin
      scr0_q <= 32'h00000000;
      scr1_q <= 32'h00000000;
      cfg_q  <= 7'h00;
    end else begin
      if (wrScr0 & ~state_q[4]) begin
        scr0_q <= pwdata;
      end
      if (wrScr1 & ~state_q[4]) begin
        scr1_q <= pwdata;
      end
      if (wrCfg) begin
        cfg_q <= pwdata[6:0];
      end
    end
  end

  // Next mode; ioFreeze decodes it and the other outputs repeat its conditions, so they change with the mode itself
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (saveInstr) begin
          if (saveOperand == `PSMC_OP_IDLE) begin
            state_d = ST_IDLE;
          end else if (arm_q) begin
            state_d = ST_DEEP;
          end else begin
            state_d = ST_SLEEP;
          end
        end
      end
      ST_SLEEP, ST_IDLE: begin
        if (wakeLite) begin
          state_d = ST_WAKE;
        end
      end
      ST_DEEP: begin
        if (|deepEv) begin
          state_d = ST_POR;
        end
      end
      ST_POR: begin
        if (porCnt_q == 8'h00) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  // Arm bit and its window. A stray set that no Sleep instruction follows
  // must not linger, or a much later Sleep would fall into Deep Sleep.
  always @(posedge clk) begin
    if (sys_rst) begin
      arm_q    <= 1'b0;
      armCnt_q <= 2'h0;
    end else begin
      if (armSet) begin
        arm_q    <= 1'b1;
        armCnt_q <= 2'h0;
      end else if (wrCtrl & ~pwdata[`PSMC_CTRL_ARM]) begin
        arm_q <= 1'b0;
      end else if (arm_q & state_q[0] & ~saveInstr) begin
        if (armCnt_q == `PSMC_ARM_CYC) begin
          arm_q <= 1'b0;
        end else begin
          armCnt_q <= armCnt_q + 2'h1;
        end
      end
      if (exitDeep) begin
        arm_q <= 1'b0;
      end
    end
  end

  // Status flags. Hardware sets follow the firmware clears, so a set in
  // the same cycle as a clear wins.
  always @(posedge clk) begin
    if (sys_rst) begin
      bor_q      <= 1'b0;
      hold_q     <= 1'b0;
      wake_q     <= 5'h00;
      deepExit_q <= 1'b0;
      int0Prev_q <= 1'b0;
    end else begin
      int0Prev_q <= int0Pin;
      if (armSet) begin
        wake_q <= 5'h00;
      end
      if (wrCtrl & ~pwdata[`PSMC_CTRL_HOLD]) begin
        hold_q <= 1'b0;
      end
      if (wrCtrl & ~pwdata[`PSMC_CTRL_BOR]) begin
        bor_q <= 1'b0;
      end
      if (wrRcause & ~pwdata[`PSMC_RC_DEEP]) begin
        deepExit_q <= 1'b0;
      end
      if (enterDeep) begin
        hold_q <= 1'b1;
      end
      if (state_q[3] & brownout) begin
        bor_q <= 1'b1;
      end
      if (exitDeep) begin
        wake_q     <= wake_q | deepEv;
        deepExit_q <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_q       <= ST_RUN;
      clkSel_q      <= 3'h0;
      porCnt_q      <= 8'h00;
      cpuRun        <= 1'b1;
      sysClkOn      <= 1'b1;
      oscOn         <= 1'b1;
      periphClkOn   <= 1'b1;
      lowPowerRcOn  <= 1'b0;
      ioFreeze      <= 1'b0;
      memPowerOn    <= 1'b1;
      wdtClear      <= 1'b0;
      irqDiscard    <= 1'b0;
      wakeToIsr     <= 1'b0;
      devicePorRst  <= 1'b0;
      clkSelRestore <= 3'h0;
    end else begin
      state_q    <= state_d;
      wdtClear   <= 1'b0;
      irqDiscard <= 1'b0;
      wakeToIsr  <= 1'b0;
      // Decoded from the next mode so pins freeze on the entry edge itself
      ioFreeze <= hold_q | isLowPower(state_d) & ~state_d[2];
      case (state_q)
        ST_RUN: begin
          if (saveInstr) begin
            clkSel_q <= clkSelRestore;
            wdtClear <= 1'b1;
            cpuRun   <= 1'b0;
            if (saveOperand == `PSMC_OP_IDLE) begin
              lowPowerRcOn <= rcNeedIdle;
            end else if (arm_q) begin
              sysClkOn     <= 1'b0;
              oscOn        <= 1'b0;
              periphClkOn  <= 1'b0;
              memPowerOn   <= 1'b0;
              irqDiscard   <= 1'b1;
              lowPowerRcOn <= rcNeedSleep;
            end else begin
              sysClkOn     <= 1'b0;
              oscOn        <= 1'b0;
              periphClkOn  <= 1'b0;
              lowPowerRcOn <= rcNeedSleep;
            end
          end
        end
        // Coincident interrupt stays pending and wakes on the next cycle
        ST_SLEEP, ST_IDLE: begin
          if (wakeLite) begin
            sysClkOn    <= 1'b1;
            oscOn       <= 1'b1;
            periphClkOn <= 1'b1;
            wakeToIsr   <= irqPending;
            lowPowerRcOn <= 1'b0;
          end
        end
        ST_DEEP: begin
          if (exitDeep) begin
            porCnt_q     <= `PSMC_POR_CYC;
            devicePorRst <= 1'b1;
            memPowerOn   <= 1'b1;
          end
        end
        ST_POR: begin
          // Events here are dropped, so flags name only the true wake cause
          if (porCnt_q == 8'h00) begin
            devicePorRst <= 1'b0;
            sysClkOn     <= 1'b1;
            oscOn        <= 1'b1;
            periphClkOn  <= 1'b1;
            lowPowerRcOn <= 1'b0;
          end else begin
            porCnt_q <= porCnt_q - 8'h01;
          end
        end
        ST_WAKE: begin
          cpuRun        <= 1'b1;
          clkSelRestore <= clkSel_q;
        end
        // Unreachable code; the mode falls back to Run, so restart the core
        default: cpuRun <= 1'b1;
      endcase
      if (wrStatus & state_q[0]) begin
        clkSelRestore <= pwdata[2:0];
      end
    end
  end

endmodule

// ===== verif/psmc_assertions.sv
`timescale 1ns/1ps
module psmc_assertions (
  input wire clk,
  input wire sys_rst,
  input wire saveInstr,
  input wire saveOperand,
  input wire irqPending,
  input wire cpuRun,
  input wire sysClkOn,
  input wire oscOn,
  input wire periphClkOn,
  input wire ioFreeze,
  input wire memPowerOn,
  input wire wdtClear,
  input wire irqDiscard,
  input wire wakeToIsr,
  input wire devicePorRst
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take;
  assign take = saveInstr && cpuRun;
  AST_HALT: assert property (take |=> !cpuRun)
    else $error("core kept running after power-save");
  AST_WDT: assert property (take |=> wdtClear)
    else $error("watchdog not cleared on entry");
  AST_SLPCLK: assert property (take && !saveOperand |=> !sysClkOn && !oscOn)
    else $error("clock left on in sleep");
  AST_FREEZE: assert property (take && !saveOperand |=> ioFreeze)
    else $error("pins not frozen in sleep");
  AST_IDLE: assert property (take && saveOperand |=> sysClkOn && periphClkOn)
    else $error("clocks stopped in idle");
  AST_WAKE: assert property (!cpuRun && memPowerOn && !devicePorRst
    && irqPending |-> ##[0:4] cpuRun)
    else $error("no wake on interrupt");
  AST_COINC: assert property (take && saveOperand && irqPending
    |=> !cpuRun ##[1:4] cpuRun)
    else $error("coincident interrupt mishandled");
  AST_PORLEN: assert property ($rose(devicePorRst) |-> devicePorRst[*8])
    else $error("exit reset too short");
  AST_PORRUN: assert property (devicePorRst |-> !cpuRun && !wakeToIsr)
    else $error("core runs during exit reset");
  AST_DEEP: assert property (irqDiscard |-> ##[0:2] !memPowerOn && !periphClkOn)
    else $error("deep sleep left power on");
  AST_ISR: assert property (wakeToIsr |-> ##[0:2] cpuRun)
    else $error("core not resumed after wake");
endmodule
bind psmc_power_save_mode_controller psmc_assertions u_chk (.clk(clk),
  .sys_rst(sys_rst), .saveInstr(saveInstr), .saveOperand(saveOperand),
  .irqPending(irqPending), .cpuRun(cpuRun), .sysClkOn(sysClkOn),
  .oscOn(oscOn), .periphClkOn(periphClkOn), .ioFreeze(ioFreeze),
  .memPowerOn(memPowerOn), .wdtClear(wdtClear), .irqDiscard(irqDiscard),
  .wakeToIsr(wakeToIsr), .devicePorRst(devicePorRst));

// ===== verif/psmc_core_model.sv
`timescale 1ns/1ps
module psmc_core_model (
  input  wire  clk,
  input  wire  cpuRun,
  input  wire  issue,
  input  wire  op,
  output logic saveInstr,
  output logic saveOperand
);
  initial begin
    saveInstr = 1'b0;
    saveOperand = 1'b0;
  end
  // A halted core fetches nothing, so no instruction outside Run
  always @(posedge clk) begin
    saveInstr <= issue && cpuRun;
    // Operand is meaningless between instructions; keep it moving
    saveOperand <= issue ? op : ~saveOperand;
  end
endmodule

// ===== verif/psmc_power_save_mode_controller_tb_top.sv
`timescale 1ns/1ps
`include "psmc_defines.vh"
module psmc_power_save_mode_controller_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rng = 32'd91930, s0, s1;
  logic        irqPending = 1'b0, wdtTimeout = 1'b0, brownout = 1'b0;
  logic        issue = 1'b0, op = 1'b0;
  logic [3:0]  ev = 4'h0;
  wire  [31:0] prdata;
  wire  [2:0]  clkSel;
  wire         pready, pslverr, saveInstr, saveOperand, cpuRun, sysClkOn;
  wire         oscOn, periphClk, reset_cause_register, ioFreeze, memPowerOn, devicePorRst;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [31:0] expQ[$];
  always #4 clk = ~clk;
  psmc_power_save_mode_controller dut (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .saveInstr(saveInstr), .saveOperand(saveOperand),
    .irqPending(irqPending), .wdtTimeout(wdtTimeout),
    .deepWdtTimeout(ev[1]), .calAlarm(ev[2]), .masterClearN(~ev[3]),
    .supplyPor(1'b0), .brownout(brownout), .int0Pin(ev[0]),
    .cpuRun(cpuRun), .sysClkOn(sysClkOn), .oscOn(oscOn),
    .periphClkOn(periphClk), .lowPowerRcOn(reset_cause_register), .ioFreeze(ioFreeze),
    .memPowerOn(memPowerOn), .wdtClear(), .irqDiscard(), .wakeToIsr(),
    .devicePorRst(devicePorRst), .clkSelRestore(clkSel));
  psmc_core_model u_core (.clk(clk), .cpuRun(cpuRun), .issue(issue),
    .op(op), .saveInstr(saveInstr), .saveOperand(saveOperand));
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk("pslverr", pslverr, paddr > `PSMC_OFS_CFG || paddr[1:0] != 2'h0);
      if (!pwrite)
        chk("prdata", prdata, expQ.pop_front());
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 0, 1);
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic go(input logic o);
    issue <= 1'b1;
    op <= o;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? cpuRun : s == 1 ? memPowerOn : devicePorRst;
  endfunction
  task automatic wt(input int s, input logic v);
    int n = 0;
    while (sig(s) !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      chk("wait", 0, 1);
      report_and_stop();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("resetOuts", {cpuRun, memPowerOn, ioFreeze, devicePorRst}, 4'hC);
    rd(`PSMC_OFS_CTRL, 32'h0);
    rd(8'h1C, 32'h0);
    go(1'b1);
    @(posedge clk);
    chk("idleClk", {cpuRun, sysClkOn, periphClk}, 3'h3);
    irqPending <= 1'b1;
    wt(0, 1'b1);
    // Interrupt still pending as the next Idle instruction executes
    go(1'b1);
    repeat (6) @(posedge clk);
    chk("coincident", cpuRun, 1'b1);
    irqPending <= 1'b0;
    $display("idle test done");
    apb(1'b1, `PSMC_OFS_STATUS, 32'h5);
    go(1'b0);
    @(posedge clk);
    chk("sleepOuts", {oscOn, sysClkOn, ioFreeze}, 3'h1);
    wdtTimeout <= 1'b1;
    @(posedge clk);
    wdtTimeout <= 1'b0;
    wt(0, 1'b1);
    chk("clkSel", clkSel, 3'h5);
    $display("sleep test done");
    apb(1'b1, `PSMC_OFS_CFG, 32'h62);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      s0 = rng;
      s1 = ~rng;
      apb(1'b1, `PSMC_OFS_SCR0, s0);
      apb(1'b1, `PSMC_OFS_SCR1, s1);
      apb(1'b1, `PSMC_OFS_CTRL, 32'h8000);
      go(1'b0);
      wt(1, 1'b0);
      brownout <= (i == 0);
      @(posedge clk);
      brownout <= 1'b0;
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      wt(2, 1'b1);
      // A second event inside the exit reset must leave no trace
      ev[1] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      wt(0, 1'b1);
      rd(`PSMC_OFS_RCAUSE, 32'h400);
      rd(`PSMC_OFS_WAKE, 32'h1 << i);
      rd(`PSMC_OFS_CTRL, i == 0 ? 32'h3 : 32'h1);
      rd(`PSMC_OFS_SCR0, s0);
      rd(`PSMC_OFS_SCR1, s1);
      chk("ioHeld", ioFreeze, 1'b1);
      apb(1'b1, `PSMC_OFS_CTRL, 32'h0);
      apb(1'b1, `PSMC_OFS_RCAUSE, 32'h0);
      @(posedge clk);
      chk("ioFree", ioFreeze, 1'b0);
      repeat (3) @(posedge clk);
      apb(1'b1, `PSMC_OFS_CTRL, 32'h8000);
      repeat (4) @(posedge clk);
      rd(`PSMC_OFS_CTRL, 32'h0);
      rd(`PSMC_OFS_WAKE, 32'h0);
      $display("deep test %0d done", i);
    end
    report_and_stop();
  end
endmodule
